// File: verilog/dpll_holdover_dco_control.sv
/*
  Control logic for two independent digital loops: loop gain, holdover
  modes with history and post filter, forced states, pull-in and slope
  clamping, frequency-word and phase-word modes.
  Assumes a plain register port, synchronous inputs and one clock.
*/
// Operation
// - Bandwidth set by register, independent of frequency plan
// - Gain from shift over four, two-power multiplier
// - Holdover steers from stored locked frequency
// - Holdover reference follows system loop enable
// - Two-bit field picks holdover mode
// - Instantaneous mode freezes current frequency
// - History interval one to 64 seconds
// - History values kept and readable
// - Averaged mode filters, loads integrator
// - Filter coefficient from shift and multiplier
// - Zero coefficient bypasses the post filter
// - Manual mode uses software 42-bit offset
// - Forced holdover ignores qualified references
// - Eight selectable pull-in ranges per loop
// - Slope limit settings, limiter can be bypassed
// - Frequency mode bypasses detector and filter
// - 42-bit frequency word applied directly
// - Word LSB weighs two to minus 53
// - Phase word runs through loop filter
// - Code 0b101 selects automatic state machine
// - Fail-to-hold sends forced tracking into holdover
`timescale 1ns/1ps

module dpll_holdover_dco_control
  import dpll_ctrl_pkg::*;
#(
  parameter int NUM_LOOPS = 2,
  parameter int HIST_DEPTH = 8,
  parameter int SEC_CYCLES = `SEC_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic system_loop_en,
  input wire loop_in_t [NUM_LOOPS-1:0] loop_in,
  output loop_out_t [NUM_LOOPS-1:0] loop_out
);

  localparam int UPD_CYCLES = `UPD_CYCLES;
  localparam int HIDX_W = (HIST_DEPTH > 1) ? $clog2(HIST_DEPTH) : 1;

  // Pull-in limits in frequency-word units (ppm * 1e-6 * 2^53)
  localparam logic [41:0] PULL_LIM [8] = '{
    42'd41433116572, 42'd108086391057, 42'd180143985095,
    42'd288230376152, 42'd468374361246, 42'd747597538143,
    42'd1179943102371, 42'd1324058290447};
  // Slope limits as frequency offset; codes 6 and 7 bypass the limiter
  localparam logic [41:0] SLOPE_LIM [6] = '{
    42'd9007199, 42'd45035996, 42'd90071993,
    42'd7971371340, 42'd67553994411, 42'd549439154539};

  // Saturate a wide value to plus or minus a magnitude
  function automatic logic signed [41:0] clamp(
    input logic signed [47:0] v, input logic [41:0] lim);
    logic signed [47:0] l;
    l = $signed({6'h00, lim});
    if (v > l) begin
      clamp = 42'(l);
    end else if (v < -l) begin
      clamp = 42'(-l);
    end else begin
      clamp = 42'(v);
    end
  endfunction

  // Shared 600 kHz update enable and one-second enable
  logic [$clog2(UPD_CYCLES)-1:0] upd_cnt;
  logic upd_tick;
  logic [31:0] sec_cnt;
  logic sec_tick;

  always_ff @(posedge clk_sys) begin
    if (rst || upd_cnt == ($clog2(UPD_CYCLES))'(UPD_CYCLES - 1)) begin
      upd_cnt <= '0;
    end else begin
      upd_cnt <= upd_cnt + 1'b1;
    end
  end
  assign upd_tick = (upd_cnt == '0) && !rst;

  // Seconds base for history storing, long so it is a parameter
  always_ff @(posedge clk_sys) begin
    if (rst || sec_cnt == 32'(SEC_CYCLES - 1)) begin
      sec_cnt <= 32'h0000_0000;
    end else begin
      sec_cnt <= sec_cnt + 32'h0000_0001;
    end
  end
  assign sec_tick = (sec_cnt == 32'(SEC_CYCLES - 1));

  logic [31:0] ch_rdata [NUM_LOOPS];

  // One copy of all control and state per loop
  genvar gi;
  generate
    for (gi = 0; gi < NUM_LOOPS; gi++) begin : g_loop
      logic [31:0] ctrl;
      logic [2:0] force_sel;
      logic fail_hold;
      logic freq_en;
      logic phase_en;
      logic [HIDX_W-1:0] hist_idx;
      logic [41:0] man_offset;
      logic [31:0] freq_lo_stage;
      logic [41:0] freq_word;
      logic signed [31:0] phase_word;
      loop_state_t state;
      loop_state_t next_state;
      logic signed [47:0] integ;
      logic signed [47:0] avg;
      logic signed [41:0] hold_val;
      logic [41:0] hist [HIST_DEPTH];
      logic [5:0] sec_seen;
      logic wr_hit;
      logic [4:0] bw_shift;
      logic [2:0] bw_mult;
      hold_mode_t hold_mode;
      logic [5:0] hold_ivl;
      logic [4:0] hf_shift;
      logic [2:0] hf_mult;
      logic [2:0] pull_sel;
      logic [2:0] slope_sel;
      logic signed [47:0] err_x;
      logic signed [47:0] gain_inc;
      logic signed [47:0] hf_step;
      logic signed [47:0] raw_tune;
      logic [41:0] lim;
      logic qual;
      logic entering_hold;

      assign wr_hit = reg_wr && (reg_addr[7:`CH_STRIDE_BIT] == 2'(gi));
      assign bw_shift = ctrl[`F_BW_SHIFT +: 5];
      assign bw_mult = ctrl[`F_BW_MULT +: 3];
      assign hold_mode = hold_mode_t'(ctrl[`F_HOLD_MODE +: 2]);
      assign hold_ivl = ctrl[`F_HOLD_IVL +: 6];
      assign hf_shift = ctrl[`F_HF_SHIFT +: 5];
      assign hf_mult = ctrl[`F_HF_MULT +: 3];
      assign pull_sel = ctrl[`F_PULL_SEL +: 3];
      assign slope_sel = ctrl[`F_SLOPE_SEL +: 3];
      assign qual = loop_in[gi].ref_qualified;

      // Control register writes
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          ctrl <= `RST_CTRL;
          force_sel <= `RST_FORCE;
          fail_hold <= 1'b0;
          freq_en <= 1'b0;
          phase_en <= 1'b0;
          hist_idx <= '0;
          man_offset <= 42'h000_0000_0000;
          phase_word <= 32'sh0000_0000;
        end else if (wr_hit) begin
          unique case (reg_addr[5:0])
            `OFS_CTRL: ctrl <= reg_wdata;
            `OFS_MODE: begin
              force_sel <= reg_wdata[`F_FORCE +: 3];
              fail_hold <= reg_wdata[`F_FAIL_HOLD];
              freq_en <= reg_wdata[`F_FREQ_EN];
              phase_en <= reg_wdata[`F_PHASE_EN];
              hist_idx <= reg_wdata[`F_HIST_IDX +: HIDX_W];
            end
            `OFS_MAN_LO: man_offset[31:0] <= reg_wdata;
            `OFS_MAN_HI: man_offset[41:32] <= reg_wdata[9:0];
            `OFS_PHASE: phase_word <= $signed(reg_wdata);
            default: ;
          endcase
        end
      end

      // Low half is staged so the oscillator never sees a torn word
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          freq_lo_stage <= 32'h0000_0000;
          freq_word <= 42'h000_0000_0000;
        end else if (wr_hit && reg_addr[5:0] == `OFS_FREQ_LO) begin
          freq_lo_stage <= reg_wdata;
        end else if (wr_hit && reg_addr[5:0] == `OFS_FREQ_HI) begin
          freq_word <= {reg_wdata[9:0], freq_lo_stage};
        end
      end

      // State selection: forced states or automatic machine
      always_comb begin
        next_state = state;
        unique case (force_sel)
          `FORCE_AUTO: begin
            unique case (state)
              ST_FREE_RUN: if (qual) next_state = ST_ACQUIRE;
              ST_ACQUIRE: begin
                if (!qual) begin
                  next_state = ST_FREE_RUN;
                end else if (loop_in[gi].ref_locked) begin
                  next_state = ST_NORMAL;
                end
              end
              ST_NORMAL: if (!qual) next_state = ST_HOLDOVER;
              ST_HOLDOVER: if (qual) next_state = ST_RECOVERY;
              ST_RECOVERY: begin
                if (!qual) begin
                  next_state = ST_HOLDOVER;
                end else if (loop_in[gi].ref_locked) begin
                  next_state = ST_NORMAL;
                end
              end
              default: next_state = ST_FREE_RUN;
            endcase
          end
          `FORCE_HOLD: next_state = ST_HOLDOVER;
          `FORCE_ACQ, `FORCE_RECOV, `FORCE_NORMAL: begin
            if (fail_hold && !qual) begin
              next_state = ST_HOLDOVER;
            end else if (force_sel == `FORCE_ACQ) begin
              next_state = ST_ACQUIRE;
            end else if (force_sel == `FORCE_RECOV) begin
              next_state = ST_RECOVERY;
            end else begin
              next_state = ST_NORMAL;
            end
          end
          default: next_state = ST_FREE_RUN;
        endcase
      end

      always_ff @(posedge clk_sys) begin
        if (rst) begin
          state <= ST_FREE_RUN;
        end else begin
          state <= next_state;
        end
      end
      assign entering_hold = (state != ST_HOLDOVER) &&
                             (next_state == ST_HOLDOVER);

      // Loop gain: shift/4 * 2^mult in word LSBs of 2^-53
      always_comb begin
        err_x = phase_en ? 48'(phase_word) : 48'(loop_in[gi].phase_err);
        gain_inc = ((err_x * $signed(48'({1'b0, bw_shift}))) <<< bw_mult)
                   >>> 2;
        hf_step = ((integ - avg) * $signed(48'({1'b0, hf_mult})))
                  >>> (`HF_SHIFT_BASE - 6'({1'b0, hf_shift}));
      end

      // Integrator runs at the update rate while tracking
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          integ <= 48'sh0000_0000_0000;
        end else if (entering_hold && hold_mode == HOLD_AVERAGED) begin
          integ <= avg;
        end else if (upd_tick && (phase_en || state == ST_ACQUIRE ||
                     state == ST_NORMAL || state == ST_RECOVERY)) begin
          integ <= integ + gain_inc;
        end
      end

      // Holdover post filter, bypassed when its coefficient is zero
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          avg <= 48'sh0000_0000_0000;
        end else if (state == ST_NORMAL) begin
          if (hf_mult == 3'h0) begin
            avg <= integ;
          end else if (upd_tick) begin
            avg <= avg + hf_step;
          end
        end
      end

      // History stored from locked operation every interval seconds
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          sec_seen <= 6'h00;
          for (int k = 0; k < HIST_DEPTH; k++) begin
            hist[k] <= 42'h000_0000_0000;
          end
        end else if (sec_tick && state == ST_NORMAL) begin
          if (sec_seen >= hold_ivl) begin
            sec_seen <= 6'h00;
            hist[0] <= 42'(hf_mult == 3'h0 ? integ : avg);
            for (int k = 1; k < HIST_DEPTH; k++) begin
              hist[k] <= hist[k-1];
            end
          end else begin
            sec_seen <= sec_seen + 6'h01;
          end
        end
      end

      // Value captured on holdover entry
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          hold_val <= 42'sh000_0000_0000;
        end else if (entering_hold) begin
          unique case (hold_mode)
            HOLD_INSTANT: hold_val <= 42'(integ);
            HOLD_HISTORY: hold_val <= $signed(hist[hist_idx]);
            HOLD_AVERAGED: hold_val <= 42'(avg);
            HOLD_MANUAL: hold_val <= $signed(man_offset);
          endcase
        end
      end

      // Frequency source selection before clamping
      always_comb begin
        if (freq_en) begin
          raw_tune = 48'($signed(freq_word));
        end else if (phase_en) begin
          raw_tune = integ;
        end else if (state == ST_HOLDOVER) begin
          raw_tune = (hold_mode == HOLD_MANUAL) ?
                     48'($signed(man_offset)) : 48'(hold_val);
        end else if (state == ST_FREE_RUN) begin
          raw_tune = 48'sh0000_0000_0000;
        end else begin
          raw_tune = integ;
        end
        lim = PULL_LIM[pull_sel];
        if (slope_sel < 3'h6 && SLOPE_LIM[slope_sel] < lim) begin
          lim = SLOPE_LIM[slope_sel];
        end
      end

      // Tuning output registered; the frequency word is not clamped
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          loop_out[gi] <= '0;
        end else begin
          loop_out[gi].tune <= freq_en ? $signed(freq_word) :
                               clamp(raw_tune, lim);
          loop_out[gi].hold_active <= (state == ST_HOLDOVER);
          loop_out[gi].hold_ref_sys <= system_loop_en;
        end
      end

      // Read mux for this loop
      always_comb begin
        ch_rdata[gi] = 32'h0000_0000;
        unique case (reg_addr[5:0])
          `OFS_CTRL: ch_rdata[gi] = ctrl;
          `OFS_MODE: ch_rdata[gi] = 32'({hist_idx, 2'b00, phase_en,
                                          freq_en, fail_hold, force_sel});
          `OFS_MAN_LO: ch_rdata[gi] = man_offset[31:0];
          `OFS_MAN_HI: ch_rdata[gi] = {22'h00_0000, man_offset[41:32]};
          `OFS_FREQ_LO: ch_rdata[gi] = freq_word[31:0];
          `OFS_FREQ_HI: ch_rdata[gi] = {22'h00_0000, freq_word[41:32]};
          `OFS_PHASE: ch_rdata[gi] = phase_word;
          `OFS_STATUS: ch_rdata[gi] = {27'h000_0000,
                                       loop_out[gi].hold_ref_sys,
                                       loop_out[gi].hold_active,
                                       state};
          `OFS_TUNE_LO: ch_rdata[gi] = loop_out[gi].tune[31:0];
          `OFS_TUNE_HI: ch_rdata[gi] = {22'h00_0000,
                                        loop_out[gi].tune[41:32]};
          `OFS_HIST_LO: ch_rdata[gi] = hist[hist_idx][31:0];
          `OFS_HIST_HI: ch_rdata[gi] = {22'h00_0000,
                                        hist[hist_idx][41:32]};
          default: ch_rdata[gi] = 32'h0000_0000;
        endcase
      end
    end
  endgenerate

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      reg_rdata <= 32'h0000_0000;
      for (int c = 0; c < NUM_LOOPS; c++) begin
        if (reg_addr[7:`CH_STRIDE_BIT] == 2'(c)) begin
          reg_rdata <= ch_rdata[c];
        end
      end
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule

// File: verilog/dpll_ctrl_cfg.svh
/*
  Offsets, field positions, reset values and timing counts for the
  two-loop holdover and digital oscillator control block.
  Assumes inclusion by bare name from the package.
*/
`ifndef DPLL_CTRL_CFG_SVH
`define DPLL_CTRL_CFG_SVH

// Clock and update timing
`define CLK_HZ 250000000
`define UPD_HZ 600000
`define UPD_CYCLES (`CLK_HZ / `UPD_HZ)
`define SEC_HZ 1
`define SEC_CYCLES (`CLK_HZ / `SEC_HZ)

// Register map, byte addresses, one block per loop
`define CH_STRIDE_BIT 6
`define OFS_CTRL 6'h00
`define OFS_MODE 6'h04
`define OFS_MAN_LO 6'h08
`define OFS_MAN_HI 6'h0c
`define OFS_FREQ_LO 6'h10
`define OFS_FREQ_HI 6'h14
`define OFS_PHASE 6'h18
`define OFS_STATUS 6'h1c
`define OFS_TUNE_LO 6'h20
`define OFS_TUNE_HI 6'h24
`define OFS_HIST_LO 6'h28
`define OFS_HIST_HI 6'h2c

// Control word fields
`define F_BW_SHIFT 0
`define F_BW_MULT 5
`define F_HOLD_MODE 8
`define F_HOLD_IVL 10
`define F_HF_SHIFT 16
`define F_HF_MULT 21
`define F_PULL_SEL 24
`define F_SLOPE_SEL 27

// Mode word fields
`define F_FORCE 0
`define F_FAIL_HOLD 3
`define F_FREQ_EN 4
`define F_PHASE_EN 5
`define F_HIST_IDX 8

// Reset values
`define RST_CTRL 32'h0000_0000
`define RST_FORCE 3'h0

// Forced state encodings
`define FORCE_FREE 3'h0
`define FORCE_ACQ 3'h1
`define FORCE_RECOV 3'h2
`define FORCE_NORMAL 3'h3
`define FORCE_HOLD 3'h4
`define FORCE_AUTO 3'h5

// Hold filter shift offset: 33 plus 2 for the divide by four
`define HF_SHIFT_BASE 6'h23

`endif

// File: verilog/dpll_ctrl_pkg.sv
/*
  Types shared by the two-loop holdover and oscillator control block.
  Assumes dpll_ctrl_cfg.svh sits on the include path.
*/
package dpll_ctrl_pkg;
  `include "dpll_ctrl_cfg.svh"

  typedef enum logic [2:0] {
    ST_FREE_RUN,
    ST_ACQUIRE,
    ST_NORMAL,
    ST_HOLDOVER,
    ST_RECOVERY
  } loop_state_t;

  typedef enum logic [1:0] {
    HOLD_INSTANT,
    HOLD_HISTORY,
    HOLD_AVERAGED,
    HOLD_MANUAL
  } hold_mode_t;

  // Per-loop inputs from reference monitor and phase detector
  typedef struct packed {
    logic ref_qualified;
    logic ref_locked;
    logic signed [31:0] phase_err;
  } loop_in_t;

  // Per-loop tuning result toward the oscillator
  typedef struct packed {
    logic signed [41:0] tune;
    logic hold_active;
    logic hold_ref_sys;
  } loop_out_t;
endpackage

// File: tb/dpll_ctrl_assertions.sv
/*
  Checker for the two-loop control block, bound to its top module.
  Assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
module dpll_ctrl_assertions
  import dpll_ctrl_pkg::*;
#(
  parameter int NUM_LOOPS = 2
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic system_loop_en,
  input wire loop_in_t [NUM_LOOPS-1:0] loop_in,
  input wire loop_out_t [NUM_LOOPS-1:0] loop_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  logic [2:0] f0;
  logic fh0;
  logic fen0;
  logic rst_d;
  logic [1:0] hm0;
  logic [31:0] lo0;
  logic [41:0] fw0;
  // Shadow of loop a settings, since the design copy is hidden
  always_ff @(posedge clk_sys) begin
    rst_d <= rst;
    if (rst) begin
      {fen0, fh0, f0} <= 5'h00;
      hm0 <= 2'h0;
      fw0 <= 42'h0;
    end else if (reg_wr) begin
      if (reg_addr == 8'h04) {fen0, fh0, f0} <= reg_wdata[4:0];
      if (reg_addr == 8'h00) hm0 <= reg_wdata[9:8];
      if (reg_addr == 8'h10) lo0 <= reg_wdata;
      if (reg_addr == 8'h14) fw0 <= {reg_wdata[9:0], lo0};
    end
  end
  sequence lost_ref_s;
    (f0 == 3'h3 && fh0 && !fen0 && !loop_in[0].ref_qualified) [*2];
  endsequence
  sequence kept_force_s;
    (f0 == 3'h3 && !fh0 && !fen0) [*3];
  endsequence
  // Writes are excluded: a new clamp setting may move a frozen value
  sequence frozen_s;
    (f0 == 3'h4 && hm0 == 2'h0 && !fen0 && !reg_wr) [*4];
  endsequence
  rd_idle_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data not zero outside a reply");
  unmapped_rd_a: assert property ($past(reg_rd) && $past(reg_addr[7])
    |-> reg_rdata == 32'h0) else $error("unmapped read not zero");
  hold_ref_a: assert property (!rst_d |-> loop_out[0].hold_ref_sys ==
    $past(system_loop_en) && loop_out[1].hold_ref_sys ==
    $past(system_loop_en)) else $error("holdover reference wrong");
  freq_direct_a: assert property (!rst_d && $past(fen0)
    |-> loop_out[0].tune == $past(fw0)) else $error("tune not word");
  force_hold_a: assert property ((f0 == 3'h4 && !fen0) [*3]
    |-> loop_out[0].hold_active) else $error("forced hold not kept");
  free_no_hold_a: assert property ((f0 == 3'h0 && !fen0) [*3]
    |-> !loop_out[0].hold_active) else $error("hold in free run");
  fail_hold_a: assert property (lost_ref_s
    |-> ##[0:3] loop_out[0].hold_active) else $error("no fail to hold");
  stay_forced_a: assert property (kept_force_s
    |-> !loop_out[0].hold_active) else $error("left forced state");
  instant_freeze_a: assert property (frozen_s
    |-> $stable(loop_out[0].tune)) else $error("hold value moved");
endmodule

bind dpll_holdover_dco_control dpll_ctrl_assertions #(
  .NUM_LOOPS(NUM_LOOPS)
) dpll_ctrl_assertions_i (
  .clk_sys(clk_sys),
  .rst(rst),
  .reg_addr(reg_addr),
  .reg_wdata(reg_wdata),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .system_loop_en(system_loop_en),
  .loop_in(loop_in),
  .loop_out(loop_out)
);

// File: tb/host_servo_model.sv
/*
  Host servo model: drives the register port as control software would.
  Assumes read data stand in the cycle after the read strobe.
*/
`timescale 1ns/1ps
module host_servo_model (
  input wire logic clk_sys,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  // Data inverted when idle so a stale value is never mistaken as live
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    reg_wdata <= ~d;
  endtask
  // Low half first, so a staged frequency word never lands half new
  task automatic wr42(input logic [7:0] a, input logic [41:0] d);
    wr(a, d[31:0]);
    wr(a + 8'h04, {22'h0, d[41:32]});
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    d = reg_rdata;
  endtask
endmodule

// File: tb/tb_dpll_holdover_dco_control.sv
/*
  Testbench for the two-loop control block with a host model on the bus.
  Assumes a 250 MHz clock and a shortened one-second count.
*/
`timescale 1ns/1ps
module tb_dpll_holdover_dco_control;
  import dpll_ctrl_pkg::*;
  logic clk_sys = 1'b0;
  logic rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic system_loop_en;
  loop_in_t [1:0] loop_in;
  loop_out_t [1:0] loop_out;
  int fail_count = 0;
  int cmp_count = 0;
  logic [31:0] d;
  logic signed [41:0] v;
  logic signed [41:0] p;
  always #2 clk_sys = ~clk_sys;
  // Short second keeps history storage within the run length
  dpll_holdover_dco_control #(.SEC_CYCLES(1000)) dpll_holdover_dco_control_i (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .system_loop_en(system_loop_en),
    .loop_in(loop_in), .loop_out(loop_out));
  host_servo_model host_servo_model_i (
    .clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  task automatic complete_run;
    $display("checks %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic ck(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      fail_count++;
      $display("MISMATCH %0t %s", $time, m);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] x);
    host_servo_model_i.wr(a, x);
  endtask
  task automatic rd(input logic [7:0] a);
    host_servo_model_i.rd(a, d);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Bounded wait for the next tune step of one loop
  task automatic wchg(input int i);
    int n;
    v = loop_out[i].tune;
    for (n = 0; n < 1000 && loop_out[i].tune === v; n++) wt(1);
    ck(n < 1000, "tune never moved");
    if (n >= 1000) complete_run();
    v = loop_out[i].tune;
  endtask
  function automatic logic [31:0] cw(input logic [4:0] s,
    input logic [2:0] m, input logic [1:0] h, input logic [2:0] pi,
    input logic [2:0] sl);
    return {2'h0, sl, pi, 14'h0, h, m, s};
  endfunction
  task automatic t_regs;
    rd(8'h00);
    ck(d === 32'h0, "ctrl reset");
    rd(8'h04);
    ck(d === 32'h0, "mode reset");
    wr(8'h00, cw(5'h1f, 3'h5, 2'h2, 3'h3, 3'h4));
    rd(8'h00);
    ck(d === cw(5'h1f, 3'h5, 2'h2, 3'h3, 3'h4), "ctrl readback");
    rd(8'h40);
    ck(d === 32'h0, "loop b ctrl shared");
    rd(8'h80);
    ck(d === 32'h0, "unmapped read");
  endtask
  task automatic t_freq;
    host_servo_model_i.wr42(8'h10, 42'h55e63b8);
    wr(8'h04, 32'h10);
    wt(3);
    ck(loop_out[0].tune === 42'sh55e63b8, "freq word a");
    host_servo_model_i.wr42(8'h50, 42'h3fffffffffb);
    wr(8'h44, 32'h10);
    wt(3);
    ck(loop_out[1].tune === 42'sh3fffffffffb, "freq word b");
    ck(loop_out[0].tune === 42'sh55e63b8, "loop a disturbed");
    wr(8'h04, 32'h0);
    wr(8'h44, 32'h0);
    wr(8'h40, cw(5'h4, 3'h0, 2'h0, 3'h7, 3'h6));
    wr(8'h58, 32'h64);
    wr(8'h44, 32'h20);
    wchg(1);
  endtask
  task automatic t_gain;
    loop_in[0] <= '{1'b1, 1'b1, 32'h3e8};
    wr(8'h00, cw(5'h4, 3'h1, 2'h0, 3'h7, 3'h6));
    wr(8'h04, 32'h3);
    wchg(0);
    p = v;
    wchg(0);
    ck(v - p === 42'sh7d0, "loop gain step");
    wt(1200);
    rd(8'h28);
    ck(d !== 32'h0, "history empty");
  endtask
  task automatic t_hold;
    wr(8'h04, 32'h4);
    wt(4);
    p = loop_out[0].tune;
    wt(1000);
    ck(loop_out[0].tune === p, "hold drift");
    ck(p !== 42'sh0, "hold lost value");
    ck(loop_out[0].hold_active === 1'b1, "not in hold");
    rd(8'h1c);
    ck(d[3:0] === 4'hb, "hold status");
  endtask
  task automatic t_fail;
    loop_in[0].ref_qualified <= 1'b0;
    wr(8'h04, 32'hb);
    wt(6);
    ck(loop_out[0].hold_active === 1'b1, "no fail hold");
    wr(8'h04, 32'h3);
    wt(6);
    ck(loop_out[0].hold_active === 1'b0, "left forced");
    loop_in[0].ref_qualified <= 1'b1;
  endtask
  task automatic t_manual;
    wr(8'h00, cw(5'h0, 3'h0, 2'h3, 3'h7, 3'h6));
    host_servo_model_i.wr42(8'h08, 42'h12345);
    wr(8'h04, 32'h4);
    wt(4);
    ck(loop_out[0].tune === 42'sh12345, "manual offset");
    host_servo_model_i.wr42(8'h08, 42'h1ffffffffff);
    wt(4);
    p = loop_out[0].tune;
    ck(p > 0 && p < 42'sh1ffffffffff, "pull-in clamp");
    wr(8'h00, cw(5'h0, 3'h0, 2'h3, 3'h0, 3'h6));
    wt(4);
    v = loop_out[0].tune;
    ck(v > 0 && v < p, "narrow pull-in");
    wr(8'h00, cw(5'h0, 3'h0, 2'h3, 3'h7, 3'h0));
    wt(4);
    v = loop_out[0].tune;
    ck(v > 0 && v < p, "slope limit");
    wr(8'h04, 32'h5);
    wt(20);
    rd(8'h1c);
    ck(d[3:0] === 4'h2, "auto state");
  endtask
  // Averaged holdover with a zero coefficient loads the live integrator
  task automatic t_avg;
    wr(8'h00, cw(5'h4, 3'h1, 2'h2, 3'h7, 3'h6));
    wr(8'h04, 32'h3);
    wchg(0);
    wr(8'h04, 32'h4);
    wt(4);
    ck(loop_out[0].tune === v, "averaged hold value");
    ck(loop_out[0].hold_active === 1'b1, "averaged not in hold");
  endtask
  task automatic t_sysref;
    system_loop_en <= 1'b1;
    wt(3);
    ck(loop_out[0].hold_ref_sys === 1'b1, "ref a");
    ck(loop_out[1].hold_ref_sys === 1'b1, "ref b");
    rd(8'h1c);
    ck(d[4] === 1'b1, "ref status");
  endtask
  initial begin
    rst = 1'b1;
    system_loop_en = 1'b0;
    loop_in = '0;
    wt(12);
    rst <= 1'b0;
    t_regs();
    t_freq();
    t_gain();
    t_hold();
    t_fail();
    t_manual();
    t_avg();
    t_sysref();
    complete_run();
  end
endmodule
